// *** verilog/pmi_pkg.sv ***
// Package: constants and types of the PHY media-independent interface block
package pmi_pkg;

    // Clock rates and divider half periods
    localparam int MCLK_HZ     = 250_000_000;
    localparam int FAST_CLK_HZ = 25_000_000;
    localparam int SLOW_CLK_HZ = 2_500_000;
    localparam int MDC_MAX_HZ  = 8_000_000;
    localparam int DIV_W       = 6;
    localparam logic [DIV_W-1:0] HALF_FAST = DIV_W'(MCLK_HZ / (2 * FAST_CLK_HZ));
    localparam logic [DIV_W-1:0] HALF_SLOW = DIV_W'(MCLK_HZ / (2 * SLOW_CLK_HZ));

    // Management register numbers
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_INT_EN   = 5'h12;
    localparam logic [4:0] REG_INT_STAT = 5'h13;
    localparam logic [4:0] REG_PIN_STAT = 5'h14;

    // Field positions
    localparam int CTRL_DUPLEX_BIT = 8;
    localparam int CTRL_SPEED_BIT  = 13;
    localparam int INT_EN_BIT      = 1;
    localparam int INT_PEND_BIT    = 2;
    localparam int PST_DIS_BIT     = 0;
    localparam int PST_CRS_BIT     = 1;
    localparam int PST_COL_BIT     = 2;

    // Reset values
    localparam logic DUPLEX_RST = 1'b0;
    localparam logic SPEED_RST  = 1'b1;
    localparam logic INT_EN_RST = 1'b0;

    // Serial management frame
    localparam logic [5:0] PRE_LEN  = 6'h20;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] HDR_LAST = 5'h0B;
    localparam logic [4:0] WR_LAST  = 5'h11;
    localparam logic [4:0] RD_BITS  = 5'h10;

    // Cycles the strap pins need to pass the synchroniser
    localparam logic [2:0] CFG_SETTLE = 3'h4;

    typedef enum logic [5:0] {
        MS_PRE   = 6'b000001,
        MS_START = 6'b000010,
        MS_HDR   = 6'b000100,
        MS_TA    = 6'b001000,
        MS_RD    = 6'b010000,
        MS_WR    = 6'b100000
    } pmi_mstate_t;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic       carrier;
        logic       collision;
        logic [3:0] data;
    } pmi_rx_line_t;

    typedef struct packed {
        logic       en;
        logic       er;
        logic [3:0] data;
    } pmi_tx_line_t;

endpackage : pmi_pkg

// *** verilog/pmi_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pmi_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q <= s3_q;
            end
        end
    end
endmodule : pmi_sync
`default_nettype wire

// *** verilog/pmi_phy_mii.sv ***
// Top: PHY side of the media-independent interface with serial management
//
// Behaviour
// RULE1: Transmit clock 2.5 or 25 MHz by speed
// RULE2: Receive clock 25 or 2.5 MHz by speed
// RULE3: Receive nibble changes with receive clock, LSB bit0
// RULE4: Receive valid high exactly with valid data
// RULE5: Receive error flagged synchronous to receive clock
// RULE6: MAC drives transmit error on transmit clock
// RULE7: Collision high for the whole collision
// RULE8: Collision asynchronous, inactive in full duplex
// RULE9: Half duplex: carrier on transmit or receive
// RULE10: Full duplex: carrier on receive only
// RULE11: Carrier rises anytime, falls on receive clock
// RULE12: Management disable ignores serial reads and writes
// RULE13: Pins load defaults, then serial channel controls
// RULE14: Station supplies management clock, at most 8 MHz
// RULE15: Shared management line, each drives in turn
// RULE16: Enabled interrupt pulls open-drain output low
// RULE17: Reading interrupt status clears, output released
// RULE18: MAC drives transmit nibble on transmit clock
// RULE19: MAC holds transmit enable over valid data
// RULE20: Disabled interrupt never pulls output low
`timescale 1ns/1ps
`default_nettype none
module pmi_phy_mii #(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic [4:0]            reg_addr,
    input  wire logic [15:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [15:0]           reg_rdata,
    output var  logic                  tx_clk,
    input  wire logic [3:0]            txd,
    input  wire logic                  tx_en,
    input  wire logic                  tx_er,
    output var  logic                  rx_clk,
    output var  logic [3:0]            rxd,
    output var  logic                  rx_dv,
    output var  logic                  rx_er,
    output var  logic                  col,
    output var  logic                  crs,
    input  wire logic                  mdc,
    input  wire logic                  mdio_i,
    output var  logic                  mdio_o,
    output var  logic                  mdio_oe,
    input  wire logic                  mgmt_disable_pin,
    input  wire logic                  cfg_duplex_pin,
    input  wire logic                  cfg_speed_pin,
    output var  logic                  status_change_irq_n_o,
    output var  logic                  status_change_irq_n_oe,
    input  wire pmi_pkg::pmi_rx_line_t rx_line,
    input  wire logic                  status_event,
    output var  pmi_pkg::pmi_tx_line_t tx_line
);
    // Synchronised pins
    logic [4:0] mg_s;
    logic [5:0] tx_s;
    logic       mdc_s;
    logic       mdio_s;
    logic       dis_s;
    logic       cfg_dup_s;
    logic       cfg_spd_s;
    pmi_sync #(.W(5)) u_sync_mgmt (
        .mclk (mclk),
        .rstn (rstn),
        .d    ({mdc, mdio_i, mgmt_disable_pin, cfg_duplex_pin, cfg_speed_pin}),
        .q    (mg_s)
    );
    pmi_sync #(.W(6)) u_sync_tx (
        .mclk (mclk),
        .rstn (rstn),
        .d    ({tx_en, tx_er, txd}),
        .q    (tx_s)
    );
    assign mdc_s     = mg_s[4];
    assign mdio_s    = mg_s[3];
    assign dis_s     = mg_s[2];
    assign cfg_dup_s = mg_s[1];
    assign cfg_spd_s = mg_s[0];
    // Control state
    logic        duplex_q;
    logic        duplex_d;
    logic        speed_q;
    logic        speed_d;
    logic        int_en_q;
    logic        int_en_d;
    logic        pend_q;
    logic        pend_d;
    logic [2:0]  cfg_cnt_q;
    logic        cfg_done_q;
    // Link clock divider
    logic [pmi_pkg::DIV_W-1:0] div_q;
    logic [pmi_pkg::DIV_W-1:0] div_d;
    logic [pmi_pkg::DIV_W-1:0] half;
    logic                      lclk_q;
    logic                      div_tick;
    logic                      fall_tick;
    // Serial management engine
    pmi_pkg::pmi_mstate_t ms_q;
    pmi_pkg::pmi_mstate_t ms_d;
    logic [5:0]  ones_q;
    logic [5:0]  ones_d;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic [15:0] sr_q;
    logic [15:0] sr_d;
    logic [15:0] shin;
    logic [4:0]  ma_q;
    logic [4:0]  ma_d;
    logic        mdio_o_d;
    logic        mdio_oe_d;
    logic        mdc_prev_q;
    logic        mdc_rise;
    logic        hdr_read;
    logic        hdr_write;
    logic        hdr_match;
    logic        m_wr;
    logic        m_rd;
    logic [15:0] m_rdata;
    logic [15:0] p_rdata;
    // Register port decode
    logic p_wr_ctrl;
    logic p_wr_inten;
    logic m_wr_ctrl;
    logic m_wr_inten;
    logic stat_read;
    // Register read multiplexer
    function automatic logic [15:0] rd_mux(input logic [4:0] a, input logic dup, input logic spd,
                                           input logic ien, input logic pnd, input logic dis,
                                           input logic cs, input logic cl);
        logic [15:0] v;
        v = 16'h0000;
        if (a == pmi_pkg::REG_CTRL) begin
            v[pmi_pkg::CTRL_DUPLEX_BIT] = dup;
            v[pmi_pkg::CTRL_SPEED_BIT]  = spd;
        end else if (a == pmi_pkg::REG_INT_EN) begin
            v[pmi_pkg::INT_EN_BIT] = ien;
        end else if (a == pmi_pkg::REG_INT_STAT) begin
            v[pmi_pkg::INT_PEND_BIT] = pnd;
        end else if (a == pmi_pkg::REG_PIN_STAT) begin
            v[pmi_pkg::PST_DIS_BIT] = dis;
            v[pmi_pkg::PST_CRS_BIT] = cs;
            v[pmi_pkg::PST_COL_BIT] = cl;
        end
        return v;
    endfunction : rd_mux
    assign p_rdata = rd_mux(reg_addr, duplex_q, speed_q, int_en_q, pend_q, dis_s, crs, col);
    assign m_rdata = rd_mux(ma_q, duplex_q, speed_q, int_en_q, pend_q, dis_s, crs, col);
    assign p_wr_ctrl  = reg_wr && (reg_addr == pmi_pkg::REG_CTRL);
    assign p_wr_inten = reg_wr && (reg_addr == pmi_pkg::REG_INT_EN);
    assign m_wr_ctrl  = m_wr && (ma_q == pmi_pkg::REG_CTRL);
    assign m_wr_inten = m_wr && (ma_q == pmi_pkg::REG_INT_EN);
    assign stat_read  = (reg_rd && (reg_addr == pmi_pkg::REG_INT_STAT))
                        || (m_rd && (ma_q == pmi_pkg::REG_INT_STAT));
    // Duplex and speed: pins during settle or while serial channel disabled
    assign duplex_d = (!cfg_done_q || dis_s) ? cfg_dup_s :                                   // RULE13
                      p_wr_ctrl ? reg_wdata[pmi_pkg::CTRL_DUPLEX_BIT] :
                      m_wr_ctrl ? sr_d[pmi_pkg::CTRL_DUPLEX_BIT] : duplex_q;
    assign speed_d  = (!cfg_done_q || dis_s) ? cfg_spd_s :                                   // RULE13
                      p_wr_ctrl ? reg_wdata[pmi_pkg::CTRL_SPEED_BIT] :
                      m_wr_ctrl ? sr_d[pmi_pkg::CTRL_SPEED_BIT] : speed_q;
    assign int_en_d = p_wr_inten ? reg_wdata[pmi_pkg::INT_EN_BIT] :
                      m_wr_inten ? sr_d[pmi_pkg::INT_EN_BIT] : int_en_q;
    // New event wins over a clearing read
    assign pend_d   = status_event || (pend_q && !stat_read);                                // RULE17

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            duplex_q   <= pmi_pkg::DUPLEX_RST;
            speed_q    <= pmi_pkg::SPEED_RST;
            int_en_q   <= pmi_pkg::INT_EN_RST;
            pend_q     <= 1'b0;
            cfg_cnt_q  <= 3'h0;
            cfg_done_q <= 1'b0;
            reg_rdata  <= 16'h0000;
        end else begin
            duplex_q   <= duplex_d;
            speed_q    <= speed_d;
            int_en_q   <= int_en_d;
            pend_q     <= pend_d;
            cfg_cnt_q  <= cfg_done_q ? cfg_cnt_q : cfg_cnt_q + 3'h1;
            cfg_done_q <= cfg_done_q || (cfg_cnt_q == pmi_pkg::CFG_SETTLE);
            reg_rdata  <= reg_rd ? p_rdata : 16'h0000;
        end
    end
    // Open-drain status interrupt
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status_change_irq_n_o  <= 1'b0;
            status_change_irq_n_oe <= 1'b0;
        end else begin
            status_change_irq_n_o  <= 1'b0;
            status_change_irq_n_oe <= pend_d && int_en_d;                                    // RULE16 RULE20
        end
    end
    // Transmit and receive clocks from one divider
    assign half      = speed_q ? pmi_pkg::HALF_FAST : pmi_pkg::HALF_SLOW;
    assign div_tick  = (div_q >= half - pmi_pkg::DIV_W'(1));
    assign div_d     = div_tick ? '0 : div_q + pmi_pkg::DIV_W'(1);
    assign fall_tick = div_tick && lclk_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_q  <= '0;
            lclk_q <= 1'b0;
            tx_clk <= 1'b0;
            rx_clk <= 1'b0;
        end else begin
            div_q  <= div_d;
            lclk_q <= lclk_q ^ div_tick;
            tx_clk <= lclk_q ^ div_tick;                                                     // RULE1
            rx_clk <= lclk_q ^ div_tick;                                                     // RULE2
        end
    end
    // Receive path, updated at the falling edge of the receive clock
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rxd   <= 4'h0;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
        end else if (fall_tick) begin
            rxd   <= rx_line.dv ? rx_line.data : 4'h0;                                      // RULE3
            rx_dv <= rx_line.dv;                                                             // RULE4
            rx_er <= rx_line.er;                                                             // RULE5
        end
    end

    // Transmit capture, half a period after the MAC launches
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_line <= '0;
        end else if (fall_tick) begin
            tx_line.en   <= tx_s[5];                                                         // RULE19
            tx_line.er   <= tx_s[4];                                                         // RULE6
            tx_line.data <= tx_s[3:0];                                                       // RULE18
        end
    end

    // Collision and carrier sense
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            col <= 1'b0;
            crs <= 1'b0;
        end else begin
            col <= rx_line.collision && !duplex_q;                                           // RULE7 RULE8
            if (rx_line.carrier || (!duplex_q && tx_line.en)) begin                          // RULE9 RULE10
                crs <= 1'b1;
            end else if (fall_tick) begin
                crs <= 1'b0;                                                                 // RULE11
            end
        end
    end

    // Serial management frame engine, sampled on management clock rise
    assign mdc_rise  = mdc_s && !mdc_prev_q;                                                 // RULE14
    assign shin      = {sr_q[14:0], mdio_s};
    assign hdr_read  = (shin[11:10] == pmi_pkg::OP_READ);
    assign hdr_write = (shin[11:10] == pmi_pkg::OP_WRITE);
    assign hdr_match = (shin[9:5] == PHY_ADDR) && !dis_s;                                    // RULE12

    always_comb begin
        ms_d      = ms_q;
        ones_d    = ones_q;
        cnt_d     = cnt_q;
        sr_d      = sr_q;
        ma_d      = ma_q;
        mdio_o_d  = mdio_o;
        mdio_oe_d = mdio_oe;
        m_wr      = 1'b0;
        m_rd      = 1'b0;
        if (mdc_rise) begin
            case (ms_q)
                pmi_pkg::MS_PRE: begin
                    mdio_oe_d = 1'b0;
                    if (mdio_s) begin
                        ones_d = (ones_q == pmi_pkg::PRE_LEN) ? ones_q : ones_q + 6'h01;
                    end else begin
                        ones_d = 6'h00;
                        if (ones_q == pmi_pkg::PRE_LEN) begin
                            ms_d = pmi_pkg::MS_START;
                        end
                    end
                end
                pmi_pkg::MS_START: begin
                    cnt_d = 5'h00;
                    ms_d  = mdio_s ? pmi_pkg::MS_HDR : pmi_pkg::MS_PRE;
                end
                pmi_pkg::MS_HDR: begin
                    sr_d  = shin;
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == pmi_pkg::HDR_LAST) begin
                        ma_d  = shin[4:0];
                        cnt_d = 5'h00;
                        if (hdr_read && hdr_match) begin
                            ms_d = pmi_pkg::MS_TA;
                        end else if (hdr_write && hdr_match) begin
                            ms_d = pmi_pkg::MS_WR;
                        end else begin
                            ms_d = pmi_pkg::MS_PRE;                                          // RULE12
                        end
                    end
                end
                pmi_pkg::MS_TA: begin
                    mdio_oe_d = 1'b1;                                                        // RULE15
                    mdio_o_d  = 1'b0;
                    sr_d      = m_rdata;
                    m_rd      = 1'b1;
                    cnt_d     = 5'h00;
                    ms_d      = pmi_pkg::MS_RD;
                end
                pmi_pkg::MS_RD: begin
                    if (cnt_q == pmi_pkg::RD_BITS) begin
                        mdio_oe_d = 1'b0;                                                    // RULE15
                        ones_d    = 6'h00;
                        ms_d      = pmi_pkg::MS_PRE;
                    end else begin
                        mdio_o_d = sr_q[15];
                        sr_d     = {sr_q[14:0], 1'b0};
                        cnt_d    = cnt_q + 5'h01;
                    end
                end
                pmi_pkg::MS_WR: begin
                    sr_d  = shin;
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == pmi_pkg::WR_LAST) begin
                        m_wr   = !dis_s;                                                     // RULE12
                        ones_d = 6'h00;
                        ms_d   = pmi_pkg::MS_PRE;
                    end
                end
                default: begin
                    ms_d      = pmi_pkg::MS_PRE;
                    mdio_oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ms_q       <= pmi_pkg::MS_PRE;
            ones_q     <= 6'h00;
            cnt_q      <= 5'h00;
            sr_q       <= 16'h0000;
            ma_q       <= 5'h00;
            mdio_o     <= 1'b0;
            mdio_oe    <= 1'b0;
            mdc_prev_q <= 1'b0;
        end else begin
            ms_q       <= ms_d;
            ones_q     <= ones_d;
            cnt_q      <= cnt_d;
            sr_q       <= sr_d;
            ma_q       <= ma_d;
            mdio_o     <= mdio_o_d;
            mdio_oe    <= mdio_oe_d;
            mdc_prev_q <= mdc_s;
        end
    end
endmodule : pmi_phy_mii
`default_nettype wire

// *** testbench/pmi_phy_mii_monitor.sv ***
// Checker: port-level assertions of the media-independent interface block
`timescale 1ns/1ps
`default_nettype none
module pmi_phy_mii_monitor (
    input wire logic                  mclk,
    input wire logic                  rstn,
    input wire logic [4:0]            reg_addr,
    input wire logic                  reg_rd,
    input wire logic                  tx_clk,
    input wire logic                  rx_clk,
    input wire logic [3:0]            rxd,
    input wire logic                  rx_dv,
    input wire logic                  rx_er,
    input wire logic                  col,
    input wire logic                  crs,
    input wire logic                  status_change_irq_n_o,
    input wire logic                  status_change_irq_n_oe,
    input wire pmi_pkg::pmi_rx_line_t rx_line,
    input wire logic                  status_event
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_clk_half_min: assert property ($rose(tx_clk) |-> tx_clk[*5]) else $error("transmit clock high too short");
    a_clk_pair_same: assert property (tx_clk == rx_clk) else $error("receive clock differs");
    a_rxd_on_clock: assert property ($changed(rxd) |-> !rx_clk) else $error("receive nibble off clock");
    a_rxd_idle_zero: assert property (!rx_dv |-> rxd == 4'h0) else $error("receive nibble without valid");
    a_rxdv_on_clock: assert property ($changed(rx_dv) |-> !rx_clk) else $error("receive valid off clock");
    a_rxer_on_clock: assert property ($changed(rx_er) |-> !rx_clk) else $error("receive error off clock");
    a_col_line_only: assert property (!rx_line.collision |=> !col) else $error("collision without cause");
    a_crs_fall_clock: assert property ($fell(crs) |-> !rx_clk) else $error("carrier dropped off clock");
    a_irq_drive_low: assert property (status_change_irq_n_oe |-> !status_change_irq_n_o) else $error("irq drives high");
    a_irq_clear_read: assert property (reg_rd && reg_addr == pmi_pkg::REG_INT_STAT && !status_event
        |-> ##[1:3] !status_change_irq_n_oe) else $error("irq not released by read");
endmodule : pmi_phy_mii_monitor

bind pmi_phy_mii pmi_phy_mii_monitor u_mon (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .col(col), .crs(crs),
    .status_change_irq_n_o(status_change_irq_n_o), .status_change_irq_n_oe(status_change_irq_n_oe),
    .rx_line(rx_line), .status_event(status_event));
`default_nettype wire

// *** testbench/pmi_mac_model.sv ***
// Partner: MAC transmit side and management station
`timescale 1ns/1ps
`default_nettype none
module pmi_mac_model (
    input  wire logic       tx_clk,
    input  wire logic       send,
    input  wire logic       bad,
    output var  logic [3:0] txd,
    output var  logic       tx_en,
    output var  logic       tx_er,
    output var  logic       mdc,
    output var  logic       md_o,
    output var  logic       md_oe,
    input  wire logic       mdio
);
    initial begin
        txd = 4'h0;
        tx_en = 1'b0;
        tx_er = 1'b0;
        mdc = 1'b0;
        md_o = 1'b0;
        md_oe = 1'b0;
    end
    // Counting nibbles on the device clock, garbage when idle
    always @(posedge tx_clk) begin
        tx_en <= send;
        tx_er <= send & bad;
        txd   <= send ? txd + 4'h1 : ~txd;
    end
    // One management frame, clock still outside it
    task automatic mdio_xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                             output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'h1, op, 5'h00, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            md_oe = (op == pmi_pkg::OP_WRITE) || (i > 17);
            md_o  = md_oe ? f[i] : ~md_o;
            #64 if (i < 16) rd[i] = mdio;
            mdc = 1'b1;
            #64 mdc = 1'b0;
        end
        md_oe = 1'b0;
        #128;
    endtask : mdio_xfer
endmodule : pmi_mac_model
`default_nettype wire

// *** testbench/pmi_phy_mii_test.sv ***
// Testbench: register, receive, transmit, interrupt and management checks
`timescale 1ns/1ps
`default_nettype none
module pmi_phy_mii_test;
    logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0, bad = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
    logic tx_clk, rx_clk, rx_dv, rx_er, col, crs, mdc, mdio_o, mdio_oe, md_o, md_oe, tx_en, tx_er;
    logic irq_o, irq_oe, mdis = 1'b0, status_event = 1'b0;
    logic [3:0] rxd, txd;
    pmi_pkg::pmi_rx_line_t rx_line = '0;
    pmi_pkg::pmi_tx_line_t tx_line;
    wire mdio = mdio_oe ? mdio_o : (md_oe ? md_o : 1'b1);
    wire irq_n = irq_oe ? irq_o : 1'b1;
    int failures = 0, checks = 0;

    always #2 mclk = ~mclk;

    pmi_phy_mii DUT (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_clk(tx_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
        .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .col(col), .crs(crs), .mdc(mdc),
        .mdio_i(mdio), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mgmt_disable_pin(mdis), .cfg_duplex_pin(1'b0),
        .cfg_speed_pin(1'b1), .status_change_irq_n_o(irq_o), .status_change_irq_n_oe(irq_oe),
        .rx_line(rx_line), .status_event(status_event), .tx_line(tx_line));
    pmi_mac_model mac (.tx_clk(tx_clk), .send(send), .bad(bad), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
        .mdc(mdc), .md_o(md_o), .md_oe(md_oe), .mdio(mdio));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_write(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [4:0] a, output logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : reg_read
    task automatic settle(input int n);
        repeat (n) @(posedge rx_clk);
        @(posedge mclk);
        #1;
    endtask : settle
    task automatic period(input logic [15:0] exp);
        time t0;
        @(posedge tx_clk) t0 = $time;
        @(posedge tx_clk) check(16'($time - t0), exp);
        @(posedge rx_clk) t0 = $time;
        @(posedge rx_clk) check(16'($time - t0), exp);
    endtask : period
    task automatic event_pulse;
        @(posedge mclk);
        status_event <= 1'b1;
        @(posedge mclk);
        status_event <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : event_pulse
    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    initial begin
        #200000;
        failures++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        repeat (8) @(posedge mclk);
        reg_read(pmi_pkg::REG_CTRL, d);
        check(d & 16'h2100, 16'h2000);
        period(16'h0028);
        @(posedge mclk);
        rx_line <= '{dv: 1'b1, er: 1'b0, carrier: 1'b1, collision: 1'b0, data: 4'hA};
        settle(2);
        check({rx_dv, rx_er, rxd}, 16'h002A);
        check(crs, 1'b1);
        @(posedge mclk);
        rx_line <= '{dv: 1'b1, er: 1'b1, carrier: 1'b1, collision: 1'b1, data: 4'h3};
        settle(2);
        check({rx_dv, rx_er, rxd}, 16'h0033);
        check(col, 1'b1);
        @(posedge mclk);
        rx_line <= '{dv: 1'b0, er: 1'b0, carrier: 1'b0, collision: 1'b1, data: 4'h6};
        settle(2);
        check({rx_dv, crs, col}, 16'h0001);
        bad <= 1'b1;
        send <= 1'b1;
        @(posedge tx_clk);
        for (int i = 0; i < 3; i++) begin
            @(posedge tx_clk) #8;
            check({tx_line.en, tx_line.er, tx_line.data}, {10'h0, 2'h3, txd - 4'h1});
        end
        check(crs, 1'b1);
        reg_write(pmi_pkg::REG_CTRL, 16'h2100);
        settle(3);
        check({crs, col}, 16'h0000);
        @(posedge mclk);
        rx_line.carrier <= 1'b1;
        settle(2);
        check(crs, 1'b1);
        reg_write(pmi_pkg::REG_INT_EN, 16'h0002);
        event_pulse();
        check(irq_n, 1'b0);
        reg_read(pmi_pkg::REG_INT_STAT, d);
        check(d[2], 1'b1);
        repeat (4) @(posedge mclk);
        check(irq_n, 1'b1);
        mac.mdio_xfer(pmi_pkg::OP_READ, pmi_pkg::REG_INT_EN, 16'h0000, d);
        check(d & 16'h0002, 16'h0002);
        mac.mdio_xfer(pmi_pkg::OP_WRITE, pmi_pkg::REG_INT_EN, 16'h0000, d);
        reg_read(pmi_pkg::REG_INT_EN, d);
        check(d & 16'h0002, 16'h0000);
        event_pulse();
        check(irq_n, 1'b1);
        reg_read(pmi_pkg::REG_INT_STAT, d);
        check(d[2], 1'b1);
        @(posedge mclk);
        mdis <= 1'b1;
        repeat (8) @(posedge mclk);
        mac.mdio_xfer(pmi_pkg::OP_WRITE, pmi_pkg::REG_INT_EN, 16'h0002, d);
        mac.mdio_xfer(pmi_pkg::OP_READ, pmi_pkg::REG_INT_EN, 16'h0000, d);
        check(d, 16'hFFFF);
        reg_read(pmi_pkg::REG_INT_EN, d);
        check(d & 16'h0002, 16'h0000);
        reg_read(pmi_pkg::REG_PIN_STAT, d);
        check(d[0], 1'b1);
        @(posedge mclk);
        mdis <= 1'b0;
        send <= 1'b0;
        repeat (8) @(posedge mclk);
        reg_write(pmi_pkg::REG_CTRL, 16'h0100);
        period(16'h0190);
        test_done();
    end
endmodule : pmi_phy_mii_test
`default_nettype wire
